// >>> verilog/ext_exec_pkg.sv
package ext_exec_pkg;
    // ==========================================================
    // Operation codes
    typedef enum logic [2:0] {
        OP_NONE,
        OP_INC_TEST_TO_W,
        OP_SKIP_NZ_BIT,
        OP_SKIP_NZ_MEM,
        OP_SUB_TO_W,
        OP_SUB_TO_MEM,
        OP_NIBBLE_EXCHANGE
    } op_t;

    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 8;
    localparam int          BIT_SEL_W     = 3;
    localparam int          NIBBLE_W      = 4;
    localparam logic [7:0]  W_RESET       = 8'h00;
    localparam logic [5:0]  FLAGS_RESET   = 6'h00;
    // Flag vector positions
    localparam int          FLAG_C        = 0;
    localparam int          FLAG_HB       = 1;
    localparam int          FLAG_Z        = 2;
    localparam int          FLAG_WRAP     = 3;
    localparam int          FLAG_SC       = 4;
    localparam int          FLAG_CZ       = 5;
    localparam int          FLAGS_W       = 6;
endpackage

// >>> verilog/sub_flag_unit.sv
`timescale 1ns/1ns
module sub_flag_unit
    import ext_exec_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    input  wire logic             prev_z,
    output logic      [WIDTH-1:0] diff,
    output logic      [FLAGS_W-1:0] flags
);
    logic [WIDTH:0]      full;
    logic [NIBBLE_W:0]   low;
    logic                wrap;

    // Half borrow needs a full nibble below the sign bit
    if (WIDTH <= NIBBLE_W) begin : g_width_bad
        $error("WIDTH must exceed a nibble");
    end

    assign full = {1'b0, minuend} - {1'b0, subtrahend};
    assign low  = {1'b0, minuend[NIBBLE_W-1:0]} - {1'b0, subtrahend[NIBBLE_W-1:0]};
    assign diff = full[WIDTH-1:0];
    assign wrap = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) &&
                  (diff[WIDTH-1] != minuend[WIDTH-1]);

    always_comb begin
        flags             = '0;
        flags[FLAG_C]     = ~full[WIDTH];
        flags[FLAG_HB]    = ~low[NIBBLE_W];
        flags[FLAG_Z]     = (diff == '0);
        flags[FLAG_WRAP]  = wrap;
        flags[FLAG_SC]    = diff[WIDTH-1] ^ wrap;
        flags[FLAG_CZ]    = (diff == '0) & prev_z;
    end
endmodule // sub_flag_unit

// >>> verilog/ext_skip_subtract_exec.sv
`timescale 1ns/1ns
// Functional notes
// - inc_test_to_w loads W with mem byte plus one; memory untouched.
// - inc_test_to_w skips next instruction when the incremented value is zero.
// - Every conditional skip takes two cycles: a dummy slot is inserted.
// - Bit test skips when the selected memory bit is set.
// - skip_if_nonzero_mem skips when the memory byte is nonzero.
// - sub_to_w writes W minus memory byte into W.
// - sub_to_mem writes W minus memory byte back to memory.
// - Subtraction carry is 0 on negative result, 1 on zero or positive.
// - Subtractions update all six flags; skips and increment touch none.
// - nibble_exchange swaps memory byte halves; flags unchanged.
module ext_skip_subtract_exec
    import ext_exec_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          op_valid,
    input  wire ext_exec_pkg::op_t             op_code,
    input  wire logic [ext_exec_pkg::ADDR_W-1:0]    op_addr,
    input  wire logic [ext_exec_pkg::BIT_SEL_W-1:0] op_bit,
    input  wire logic [ext_exec_pkg::DATA_W-1:0]    mem_rdata,
    output logic                               busy,
    output logic                               skip_next,
    output logic                               mem_we,
    output logic [ext_exec_pkg::ADDR_W-1:0]    mem_addr,
    output logic [ext_exec_pkg::DATA_W-1:0]    mem_wdata,
    output logic [ext_exec_pkg::DATA_W-1:0]    working_register,
    output logic [ext_exec_pkg::FLAGS_W-1:0]   flags
);
    import ext_exec_pkg::*;

    // ==========================================================
    // Sequencing
    typedef enum logic [0:0] {ST_RUN, ST_DUMMY} state_t;

    state_t                  state_r;
    logic [DATA_W-1:0]       inc_val;
    logic [DATA_W-1:0]       diff;
    logic [FLAGS_W-1:0]      sub_flags;
    logic                    take;
    logic                    skip_cond;

    function automatic logic is_skip(input op_t op);
        return op == OP_INC_TEST_TO_W || op == OP_SKIP_NZ_BIT || op == OP_SKIP_NZ_MEM;
    endfunction

    function automatic logic is_sub(input op_t op);
        return op == OP_SUB_TO_W || op == OP_SUB_TO_MEM;
    endfunction

    // New ops are ignored while the dummy slot runs
    assign take    = op_valid && state_r == ST_RUN;
    assign inc_val = mem_rdata + 8'h01;

    sub_flag_unit #(.WIDTH(DATA_W)) u_sub (
        .minuend    (working_register),
        .subtrahend (mem_rdata),
        .prev_z     (flags[FLAG_Z]),
        .diff       (diff),
        .flags      (sub_flags)
    );

    always_comb begin
        skip_cond = 1'b0;
        unique case (op_code)
            OP_INC_TEST_TO_W: skip_cond = (inc_val == 8'h00);
            OP_SKIP_NZ_BIT:   skip_cond = mem_rdata[op_bit];
            OP_SKIP_NZ_MEM:   skip_cond = (mem_rdata != 8'h00);
            default:          skip_cond = 1'b0;
        endcase
    end

    // ==========================================================
    // Two-cycle skip handling
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_RUN;
        end else if (take && is_skip(op_code)) begin
            state_r <= ST_DUMMY;
        end else begin
            state_r <= ST_RUN;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy      <= 1'b0;
            skip_next <= 1'b0;
        end else begin
            busy      <= take && is_skip(op_code);
            skip_next <= take && is_skip(op_code) && skip_cond;
        end
    end

    // ==========================================================
    // Working register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            working_register <= W_RESET;
        end else if (take && op_code == OP_INC_TEST_TO_W) begin
            working_register <= inc_val;
        end else if (take && op_code == OP_SUB_TO_W) begin
            working_register <= diff;
        end
    end

    // ==========================================================
    // Memory write port; increment-test never writes memory
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end else begin
            mem_we    <= 1'b0;
            mem_addr  <= op_addr;
            if (take && op_code == OP_SUB_TO_MEM) begin
                mem_we    <= 1'b1;
                mem_wdata <= diff;
            end else if (take && op_code == OP_NIBBLE_EXCHANGE) begin
                mem_we    <= 1'b1;
                mem_wdata <= {mem_rdata[3:0], mem_rdata[7:4]};
            end
        end
    end

    // ==========================================================
    // Flags: only subtraction touches them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= FLAGS_RESET;
        end else if (take && is_sub(op_code)) begin
            flags <= sub_flags;
        end
    end
endmodule // ext_skip_subtract_exec

// >>> verif/ext_skip_subtract_exec_chk.sv
`timescale 1ns/1ns
module ext_skip_subtract_exec_chk
    import ext_exec_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       op_valid,
    input wire op_t        op_code,
    input wire logic [2:0] op_bit,
    input wire logic [7:0] mem_rdata,
    input wire logic       busy,
    input wire logic       skip_next,
    input wire logic       mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] working_register,
    input wire logic [5:0] flags
);
    // ========================
    // Checks
    wire tk = op_valid && !busy;
    wire sk = op_code inside {OP_INC_TEST_TO_W, OP_SKIP_NZ_BIT, OP_SKIP_NZ_MEM};
    wire sb = op_code inside {OP_SUB_TO_W, OP_SUB_TO_MEM};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_inc_w_load: assert property (tk && op_code == OP_INC_TEST_TO_W |=>
        !mem_we && working_register == $past(mem_rdata) + 8'h01) else $error("inc");
    a_skip_dummy: assert property (tk && sk |=> busy && $stable(flags)) else $error("skip");
    a_busy_pulse: assert property (busy |=> !busy) else $error("busy");
    a_bit_skip: assert property (tk && op_code == OP_SKIP_NZ_BIT |=>
        skip_next == $past(mem_rdata[op_bit])) else $error("bit");
    a_byte_skip: assert property (tk && op_code == OP_SKIP_NZ_MEM |=>
        skip_next == ($past(mem_rdata) != 8'h00)) else $error("nz");
    a_sub_w: assert property (tk && op_code == OP_SUB_TO_W |=>
        working_register == $past(working_register - mem_rdata)) else $error("subw");
    a_sub_mem: assert property (tk && op_code == OP_SUB_TO_MEM |=>
        mem_we && mem_wdata == $past(working_register - mem_rdata)) else $error("subm");
    a_sub_carry: assert property (tk && sb |=>
        flags[FLAG_C] == $past(working_register >= mem_rdata)) else $error("carry");
    a_sub_zero: assert property (tk && op_code == OP_SUB_TO_W |=>
        flags[FLAG_Z] == (working_register == 8'h00)) else $error("zero");
    a_swap_mem: assert property (tk && op_code == OP_NIBBLE_EXCHANGE |=> $stable(flags)
        && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) else $error("swap");
endmodule // ext_skip_subtract_exec_chk

bind ext_skip_subtract_exec ext_skip_subtract_exec_chk chk_i (.clk, .rst_b, .op_valid, .op_code,
    .op_bit, .mem_rdata, .busy, .skip_next, .mem_we, .mem_wdata, .working_register, .flags);

// >>> verif/ext_skip_subtract_exec_tb.sv
`timescale 1ns/1ns
module ext_skip_subtract_exec_tb;
    import ext_exec_pkg::*;
    logic clk = 0, rst_b = 0, op_valid = 0, busy, skip_next, mem_we;
    op_t  op_code = OP_NONE;
    logic [7:0] op_addr = 8'h00, mem_rdata = 8'h00, mem_addr, mem_wdata, working_register;
    logic [7:0] ew = 8'h00, d;
    logic [5:0] flags, ef = 6'h00;
    logic [2:0] op_bit = 3'h0;
    integer seed = 32'h4d73, num_errors = 0, checks = 0, i;
    ext_skip_subtract_exec ext_skip_subtract_exec_i (.clk, .rst_b, .op_valid, .op_code,
        .op_addr, .op_bit, .mem_rdata, .busy, .skip_next, .mem_we, .mem_addr, .mem_wdata,
        .working_register, .flags);
    always #25 clk = ~clk;
    // ========================
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic do_op(input op_t c, input logic [7:0] m, input logic [2:0] b);
        logic sk, we;
        logic [7:0] wd;
        sk = 0;
        we = 0;
        wd = 8'h00;
        @(posedge clk);
        op_valid <= 1;
        op_code <= c;
        mem_rdata <= m;
        op_bit <= b;
        op_addr <= ~m;
        case (c)
            OP_INC_TEST_TO_W: begin
                ew = m + 8'h01;
                sk = ew == 8'h00;
            end
            OP_SKIP_NZ_BIT: sk = m[b];
            OP_SKIP_NZ_MEM: sk = m != 8'h00;
            OP_SUB_TO_W, OP_SUB_TO_MEM: begin
                d = ew - m;
                ef[FLAG_C] = ew >= m;
                ef[FLAG_HB] = ew[3:0] >= m[3:0];
                ef[FLAG_CZ] = d == 8'h00 && ef[FLAG_Z];
                ef[FLAG_Z] = d == 8'h00;
                ef[FLAG_WRAP] = ew[7] != m[7] && d[7] != ew[7];
                ef[FLAG_SC] = d[7] ^ ef[FLAG_WRAP];
                we = c == OP_SUB_TO_MEM;
                wd = d;
                if (!we) ew = d;
            end
            OP_NIBBLE_EXCHANGE: begin
                we = 1;
                wd = {m[3:0], m[7:4]};
            end
            default: ;
        endcase
        @(posedge clk);
        op_valid <= 0;
        @(negedge clk);
        chk(working_register, ew);
        chk({2'b00, flags}, {2'b00, ef});
        chk({busy, skip_next, mem_we, 5'h00},
            {c inside {OP_INC_TEST_TO_W, OP_SKIP_NZ_BIT, OP_SKIP_NZ_MEM}, sk, we, 5'h00});
        if (we) chk(mem_wdata, wd);
        if (we) chk(mem_addr, ~m);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        // Edge values: wrap to zero, equal operands, signed overflow
        do_op(OP_INC_TEST_TO_W, 8'hff, 3'h0);
        do_op(OP_SUB_TO_W, 8'h00, 3'h0);
        do_op(OP_SUB_TO_W, 8'h00, 3'h0);
        do_op(OP_INC_TEST_TO_W, 8'h7f, 3'h0);
        do_op(OP_SUB_TO_MEM, 8'h01, 3'h0);
        do_op(OP_SKIP_NZ_BIT, 8'h7f, 3'h7);
        for (i = 0; i < 400; i++)
            do_op(op_t'(3'($unsigned($random(seed)) % 7)), 8'($random(seed)), 3'($random(seed)));
        give_verdict;
    end
    initial begin
        #200000;
        num_errors++;
        give_verdict;
    end
endmodule // ext_skip_subtract_exec_tb
